//--- verilog/tcc_pkg.sv
/*
 * Constants for the timer with one capture/compare channel: register offsets,
 * control field positions and reset values.
 * Assumes a single 200 MHz clock and a plain strobe register port.
 */
package tcc_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 16;

   // Register byte offsets
   localparam logic [7:0] OFS_COUNT = 8'h00;
   localparam logic [7:0] OFS_CTL = 8'h04;
   localparam logic [7:0] OFS_CCR = 8'h08;
   localparam logic [7:0] OFS_PERIOD = 8'h0C;
   localparam logic [7:0] OFS_RUN = 8'h10;
   localparam logic [7:0] OFS_STS = 8'h14;
   localparam logic [7:0] OFS_MSK = 8'h18;

   // Channel control field positions
   localparam int EDGE_HI = 15;
   localparam int EDGE_LO = 14;
   localparam int SRC_HI = 13;
   localparam int SRC_LO = 12;
   localparam int SYNC_BIT = 11;
   localparam int LATCH_BIT = 10;
   localparam int CAP_BIT = 8;
   localparam int MODE_HI = 7;
   localparam int MODE_LO = 5;
   localparam int IE_BIT = 4;
   localparam int LEVEL_BIT = 3;
   localparam int OUTV_BIT = 2;
   localparam int COV_BIT = 1;
   localparam int FLAG_BIT = 0;

   // Interrupt status bits
   localparam int STS_W = 3;
   localparam int STS_EVENT = 0;
   localparam int STS_OVF = 1;
   localparam int STS_WRAP = 2;

   // Encodings
   localparam logic [1:0] EDGE_NONE = 2'h0;
   localparam logic [1:0] EDGE_RISE = 2'h1;
   localparam logic [1:0] EDGE_FALL = 2'h2;
   localparam logic [1:0] EDGE_BOTH = 2'h3;
   localparam logic [1:0] SRC_A = 2'h0;
   localparam logic [1:0] SRC_B = 2'h1;
   localparam logic [1:0] SRC_LOW = 2'h2;
   localparam logic [1:0] SRC_HIGH = 2'h3;

   typedef enum logic [2:0] {
      MODE_OUTBIT = 3'b000,
      MODE_SET = 3'b001,
      MODE_TOG_RST = 3'b010,
      MODE_SET_RST = 3'b011,
      MODE_TOG = 3'b100,
      MODE_RST = 3'b101,
      MODE_TOG_SET = 3'b110,
      MODE_RST_SET = 3'b111
   } drive_mode_t;

   // Reset values
   localparam logic [15:0] RST_COUNT = 16'h0000;
   localparam logic [15:0] RST_CCR = 16'h0000;
   localparam logic [15:0] RST_PERIOD = 16'hFFFF;
   localparam logic [15:0] RST_ZERO = 16'h0000;
endpackage : tcc_pkg

//--- verilog/input_sync.sv
/*
 * Two-stage synchroniser for pin-level inputs.
 * Assumes inputs are asynchronous to clk_i; only stage two is read outside.
 */
module input_sync #(
   parameter int W = 2
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);
   logic [W-1:0] meta_ff;
   logic [W-1:0] q_ff;

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         meta_ff <= '0;
         q_ff <= '0;
      end else begin
         meta_ff <= d_i;
         q_ff <= meta_ff;
      end
   end

   assign q_o = q_ff;
endmodule : input_sync

//--- verilog/pin_drive_unit.sv
/*
 * Channel output stage: eight drive modes steered by compare and period match.
 * Assumes match pulses are one cycle wide and come from the same clock.
 */
module pin_drive_unit
   import tcc_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [2:0] mode_i,
   input wire logic out_value_i,
   input wire logic match_i,
   input wire logic period_match_i,
   output logic pin_o
);
   logic out_ff;
   logic nxt_out;

   // Period match acts after match when both land together
   always_comb begin
      nxt_out = out_ff;
      unique case (drive_mode_t'(mode_i))
         MODE_OUTBIT: nxt_out = out_value_i;
         MODE_SET: if (match_i) nxt_out = 1'b1;
         MODE_TOG_RST: begin
            if (match_i) nxt_out = !out_ff;
            if (period_match_i) nxt_out = 1'b0;
         end
         MODE_SET_RST: begin
            if (match_i) nxt_out = 1'b1;
            if (period_match_i) nxt_out = 1'b0;
         end
         MODE_TOG: if (match_i) nxt_out = !out_ff;
         MODE_RST: if (match_i) nxt_out = 1'b0;
         MODE_TOG_SET: begin
            if (match_i) nxt_out = !out_ff;
            if (period_match_i) nxt_out = 1'b1;
         end
         MODE_RST_SET: begin
            if (match_i) nxt_out = 1'b0;
            if (period_match_i) nxt_out = 1'b1;
         end
      endcase
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         out_ff <= 1'b0;
      end else begin
         out_ff <= nxt_out;
      end
   end

   assign pin_o = out_ff;

   a_toggle_on_match: assert property (@(posedge clk_i) disable iff (rst_i)
      (mode_i == 3'b100 && match_i) |=> (pin_o != $past(pin_o)))
      else $error("toggle mode did not toggle on match");
   a_setrst_period: assert property (@(posedge clk_i) disable iff (rst_i)
      (mode_i == 3'b011 && period_match_i) |=> !pin_o)
      else $error("set/reset mode not low after period match");
endmodule : pin_drive_unit

//--- verilog/timer_capture_compare_control.sv
/*
 * 16-bit timer with one capture/compare channel, its control register,
 * interrupt status/mask and a plain strobe register port.
 * Assumes one clock; input lines are asynchronous pins.
 */
// The plain strobed port and the address map were chosen for this implementation.
module timer_capture_compare_control
   import tcc_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [tcc_pkg::ADDR_W-1:0] addr_i,
   input wire logic [tcc_pkg::DATA_W-1:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [tcc_pkg::DATA_W-1:0] rdata_o,
   input wire logic input_a_line_i,
   input wire logic input_b_line_i,
   output logic pin_o,
   output logic irq_o
);
   import tcc_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // Input synchronisation and source selection

   logic [1:0] lines_sync;
   logic sel_in;
   logic sel_d_ff;
   logic prev_ff;
   logic det_in;
   logic rise;
   logic fall;
   logic cap_evt;

   input_sync #(
      .W(2)
   ) u_sync (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .d_i({input_b_line_i, input_a_line_i}),
      .q_o(lines_sync)
   );

   logic [1:0] edge_sel_ff;
   logic [1:0] src_sel_ff;
   logic sync_en_ff;
   logic latch_ff;
   logic cap_mode_ff;
   logic [2:0] mode_ff;
   logic ie_ff;
   logic outv_ff;
   logic cov_ff;
   logic flag_ff;

   always_comb begin
      unique case (src_sel_ff)
         SRC_A: sel_in = lines_sync[0];
         SRC_B: sel_in = lines_sync[1];
         SRC_LOW: sel_in = 1'b0;
         SRC_HIGH: sel_in = 1'b1;
      endcase
   end

   // Sync mode costs one cycle of latency but aligns capture to the count
   assign det_in = sync_en_ff ? sel_d_ff : sel_in;
   assign rise = det_in && !prev_ff;
   assign fall = !det_in && prev_ff;

   always_comb begin
      unique case (edge_sel_ff)
         EDGE_NONE: cap_evt = 1'b0;
         EDGE_RISE: cap_evt = rise;
         EDGE_FALL: cap_evt = fall;
         EDGE_BOTH: cap_evt = rise || fall;
      endcase
      cap_evt = cap_evt && cap_mode_ff;
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         sel_d_ff <= 1'b0;
         prev_ff <= 1'b0;
      end else begin
         sel_d_ff <= sel_in;
         prev_ff <= det_in;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Counter, compare register and period

   logic [15:0] count_ff;
   logic [15:0] nxt_count;
   logic [15:0] ccr_ff;
   logic [15:0] nxt_ccr;
   logic [15:0] period_ff;
   logic [15:0] nxt_period;
   logic run_ff;
   logic nxt_run;
   logic match;
   logic period_match;
   logic wr_count;
   logic wr_ctl;
   logic wr_ccr;

   assign wr_count = wr_i && addr_i == OFS_COUNT;
   assign wr_ctl = wr_i && addr_i == OFS_CTL;
   assign wr_ccr = wr_i && addr_i == OFS_CCR;

   // A written count equal to the compare value raises a match like any other count
   assign match = run_ff && count_ff == ccr_ff;
   assign period_match = run_ff && count_ff == period_ff;

   always_comb begin
      nxt_count = count_ff;
      if (wr_count) begin
         nxt_count = wdata_i;
      end else if (period_match) begin
         nxt_count = RST_COUNT;
      end else if (run_ff) begin
         nxt_count = 16'(count_ff + 16'h0001);
      end
      nxt_ccr = ccr_ff;
      if (cap_evt) begin
         nxt_ccr = count_ff;
      end else if (wr_ccr) begin
         nxt_ccr = wdata_i;
      end
      nxt_period = (wr_i && addr_i == OFS_PERIOD) ? wdata_i : period_ff;
      nxt_run = (wr_i && addr_i == OFS_RUN) ? wdata_i[0] : run_ff;
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         count_ff <= RST_COUNT;
         ccr_ff <= RST_CCR;
         period_ff <= RST_PERIOD;
         run_ff <= 1'b0;
      end else begin
         count_ff <= nxt_count;
         ccr_ff <= nxt_ccr;
         period_ff <= nxt_period;
         run_ff <= nxt_run;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Channel control register

   logic [15:0] ctl_rd;
   logic chan_evt;
   logic nxt_flag;
   logic nxt_cov;
   logic nxt_latch;
   logic [11:0] nxt_cfg;
   logic [11:0] cfg_q;

   assign chan_evt = cap_evt || (!cap_mode_ff && match);
   assign cfg_q = {edge_sel_ff, src_sel_ff, sync_en_ff, cap_mode_ff, mode_ff, ie_ff,
                   outv_ff, 1'b0};

   always_comb begin
      nxt_cfg = cfg_q;
      if (wr_ctl) begin
         nxt_cfg = {wdata_i[EDGE_HI:EDGE_LO], wdata_i[SRC_HI:SRC_LO], wdata_i[SYNC_BIT],
                    wdata_i[CAP_BIT], wdata_i[MODE_HI:MODE_LO], wdata_i[IE_BIT],
                    wdata_i[OUTV_BIT], 1'b0};
      end
      // Hardware set wins over a software clear in the same cycle
      nxt_flag = (wr_ctl ? wdata_i[FLAG_BIT] : flag_ff) || chan_evt;
      nxt_cov = (wr_ctl ? wdata_i[COV_BIT] : cov_ff) || (cap_evt && flag_ff);
      nxt_latch = match ? sel_in : latch_ff;
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         edge_sel_ff <= 2'h0;
         src_sel_ff <= 2'h0;
         sync_en_ff <= 1'b0;
         cap_mode_ff <= 1'b0;
         mode_ff <= 3'h0;
         ie_ff <= 1'b0;
         outv_ff <= 1'b0;
         flag_ff <= 1'b0;
         cov_ff <= 1'b0;
         latch_ff <= 1'b0;
      end else begin
         {edge_sel_ff, src_sel_ff, sync_en_ff, cap_mode_ff, mode_ff, ie_ff, outv_ff} <=
            nxt_cfg[11:1];
         flag_ff <= nxt_flag;
         cov_ff <= nxt_cov;
         latch_ff <= nxt_latch;
      end
   end

   always_comb begin
      ctl_rd = RST_ZERO;
      ctl_rd[EDGE_HI:EDGE_LO] = edge_sel_ff;
      ctl_rd[SRC_HI:SRC_LO] = src_sel_ff;
      ctl_rd[SYNC_BIT] = sync_en_ff;
      ctl_rd[LATCH_BIT] = latch_ff;
      ctl_rd[CAP_BIT] = cap_mode_ff;
      ctl_rd[MODE_HI:MODE_LO] = mode_ff;
      ctl_rd[IE_BIT] = ie_ff;
      ctl_rd[LEVEL_BIT] = sel_in;
      ctl_rd[OUTV_BIT] = outv_ff;
      ctl_rd[COV_BIT] = cov_ff;
      ctl_rd[FLAG_BIT] = flag_ff;
   end

   // Channel zero would see match equal to period match; modes 2,3,6,7 useless there
   pin_drive_unit u_drive (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .mode_i(mode_ff),
      .out_value_i(outv_ff),
      .match_i(match),
      .period_match_i(period_match),
      .pin_o(pin_o)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Interrupt status and mask

   logic [STS_W-1:0] sts_ff;
   logic [STS_W-1:0] nxt_sts;
   logic [STS_W-1:0] msk_ff;
   logic [STS_W-1:0] nxt_msk;
   logic [STS_W-1:0] sts_set;
   logic [STS_W-1:0] irq_gate;

   assign sts_set = {period_match, cap_evt && flag_ff, chan_evt};
   // Event term also needs the channel enable
   assign irq_gate = {msk_ff[STS_WRAP], msk_ff[STS_OVF], msk_ff[STS_EVENT] && ie_ff};

   always_comb begin
      nxt_sts = sts_ff;
      if (wr_i && addr_i == OFS_STS) begin
         nxt_sts = sts_ff & ~wdata_i[STS_W-1:0];
      end
      nxt_sts = nxt_sts | sts_set;
      nxt_msk = (wr_i && addr_i == OFS_MSK) ? wdata_i[STS_W-1:0] : msk_ff;
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         sts_ff <= '0;
         msk_ff <= '0;
      end else begin
         sts_ff <= nxt_sts;
         msk_ff <= nxt_msk;
      end
   end

   assign irq_o = |(sts_ff & irq_gate);

   ////////////////////////////////////////////////////////////////////////////
   // Read port

   logic [15:0] rdata_ff;
   logic [15:0] nxt_rdata;

   always_comb begin
      nxt_rdata = RST_ZERO;
      if (rd_i) begin
         unique case (addr_i)
            OFS_COUNT: nxt_rdata = count_ff;
            OFS_CTL: nxt_rdata = ctl_rd;
            OFS_CCR: nxt_rdata = ccr_ff;
            OFS_PERIOD: nxt_rdata = period_ff;
            OFS_RUN: nxt_rdata = {15'h0000, run_ff};
            OFS_STS: nxt_rdata = {13'h0000, sts_ff};
            OFS_MSK: nxt_rdata = {13'h0000, msk_ff};
            default: nxt_rdata = RST_ZERO;
         endcase
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         rdata_ff <= RST_ZERO;
      end else begin
         rdata_ff <= nxt_rdata;
      end
   end

   assign rdata_o = rdata_ff;

   ////////////////////////////////////////////////////////////////////////////
   // Checks

   a_edge_none: assert property (@(posedge clk_i) disable iff (rst_i)
      edge_sel_ff == 2'h0 |-> !cap_evt)
      else $error("capture with edge select off");
   a_rise_capture: assert property (@(posedge clk_i) disable iff (rst_i)
      (cap_mode_ff && edge_sel_ff == 2'h1 && det_in && !prev_ff)
      |=> ccr_ff == $past(count_ff))
      else $error("rising edge did not capture count");
   a_src_const: assert property (@(posedge clk_i) disable iff (rst_i)
      src_sel_ff[1] |-> sel_in == src_sel_ff[0])
      else $error("constant source level wrong");
   a_sync_stage: assert property (@(posedge clk_i) disable iff (rst_i)
      (sync_en_ff && $past(sync_en_ff)) |-> det_in == $past(sel_in))
      else $error("sync capture not delayed one stage");
   a_mode0_pin: assert property (@(posedge clk_i) disable iff (rst_i)
      (mode_ff == 3'h0 && $past(mode_ff) == 3'h0) |-> pin_o == $past(outv_ff))
      else $error("mode zero pin not following out value");
   a_irq_blocked: assert property (@(posedge clk_i) disable iff (rst_i)
      (!ie_ff && (sts_ff[2:1] & msk_ff[2:1]) == 2'h0) |-> !irq_o)
      else $error("interrupt passed with enable clear");
   a_cov_set: assert property (@(posedge clk_i) disable iff (rst_i)
      (cap_evt && flag_ff) |=> cov_ff)
      else $error("overflow not set");
   a_cov_sticky: assert property (@(posedge clk_i) disable iff (rst_i)
      (cov_ff && !wr_ctl) |=> cov_ff)
      else $error("overflow cleared by hardware");
   a_compare_flag: assert property (@(posedge clk_i) disable iff (rst_i)
      (!cap_mode_ff && match) |=> flag_ff)
      else $error("compare match did not set flag");
   a_count_read: assert property (@(posedge clk_i) disable iff (rst_i)
      (rd_i && addr_i == OFS_COUNT) |=> rdata_o == $past(count_ff))
      else $error("count read mismatch");
   a_level_read: assert property (@(posedge clk_i) disable iff (rst_i)
      (rd_i && addr_i == OFS_CTL) |=> rdata_o[3] == $past(sel_in))
      else $error("input level bit wrong");

   c_capture: cover property (@(posedge clk_i) disable iff (rst_i) cap_evt);
   c_overflow: cover property (@(posedge clk_i) disable iff (rst_i) cap_evt && flag_ff);
   c_irq: cover property (@(posedge clk_i) disable iff (rst_i) irq_o);
endmodule : timer_capture_compare_control

//--- testbench/testbench.sv
/*
 * Self-checking bench for the timer capture/compare block: register port,
 * output drive modes, capture edges, overflow and interrupt gating.
 * Assumes the design package tcc_pkg and one 200 MHz clock.
 */
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import tcc_pkg::*;

   `define CHK(got, exp, msk) begin checked++; if (((got) & (msk)) !== ((exp) & (msk))) begin \
      fail_count++; $display("unexpected at %0t: got %h want %h", $time, got, exp); end end

   typedef struct {
      logic [15:0] val;
      logic [15:0] msk;
      bit probe;
   } note_t;

   logic clk_i;
   logic rst_i;
   logic [ADDR_W-1:0] addr_i;
   logic [DATA_W-1:0] wdata_i;
   logic wr_i;
   logic rd_i;
   logic [DATA_W-1:0] rdata_o;
   logic input_a_line_i;
   logic input_b_line_i;
   logic pin_o;
   logic irq_o;
   logic rd_d;
   logic probe;
   int fail_count;
   int checked;
   int seed;
   note_t notes[$];
   note_t n;
   logic [15:0] got;
   logic [15:0] cval;
   logic lvl;

   timer_capture_compare_control u_dut (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .addr_i(addr_i),
      .wdata_i(wdata_i),
      .wr_i(wr_i),
      .rd_i(rd_i),
      .rdata_o(rdata_o),
      .input_a_line_i(input_a_line_i),
      .input_b_line_i(input_b_line_i),
      .pin_o(pin_o),
      .irq_o(irq_o)
   );

   initial begin
      clk_i = 1'b0;
      forever #2.5 clk_i = ~clk_i;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Bus tasks: rd_chk and probe_chk note their expectation before the result can appear

   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
   endtask : wr

   task automatic rd_chk(input logic [7:0] a, input logic [15:0] e, input logic [15:0] m);
      notes.push_back('{val: e, msk: m, probe: 1'b0});
      @(posedge clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
   endtask : rd_chk

   // Bit 1 is the channel pin, bit 0 the interrupt line
   task automatic probe_chk(input logic [15:0] e, input logic [15:0] m);
      notes.push_back('{val: e, msk: m, probe: 1'b1});
      @(posedge clk_i);
      probe <= 1'b1;
      @(posedge clk_i);
      probe <= 1'b0;
   endtask : probe_chk

   task automatic idle(input int c);
      repeat (c) @(posedge clk_i);
   endtask : idle

   task automatic tally_and_finish;
      $display("comparisons %0d, mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : tally_and_finish

   ////////////////////////////////////////////////////////////////////////////////
   // Monitor: takes the oldest note whenever a read answer or probe stands

   always @(posedge clk_i) begin
      if (rd_d || probe) begin
         if (notes.size() == 0) begin
            fail_count++;
            $display("unexpected at %0t: result with no note", $time);
         end else begin
            n = notes.pop_front();
            got = n.probe ? {14'h0000, pin_o, irq_o} : rdata_o;
            `CHK(got, n.val, n.msk)
         end
      end
      rd_d <= rd_i;
   end

   initial begin
      idle(20000);
      fail_count++;
      tally_and_finish();
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence

   initial begin
      rst_i = 1'b1;
      addr_i = '0;
      wdata_i = '0;
      wr_i = 1'b0;
      rd_i = 1'b0;
      input_a_line_i = 1'b0;
      input_b_line_i = 1'b0;
      rd_d = 1'b0;
      probe = 1'b0;
      fail_count = 0;
      checked = 0;
      seed = 32'h3cdf;
      idle(16);
      rst_i <= 1'b0;
      rd_chk(OFS_COUNT, 16'h0000, 16'hffff);
      rd_chk(OFS_CTL, 16'h0000, 16'hffff);
      rd_chk(OFS_CCR, RST_CCR, 16'hffff);
      rd_chk(OFS_PERIOD, RST_PERIOD, 16'hffff);
      rd_chk(8'h1c, 16'h0000, 16'hffff);
      probe_chk(16'h0000, 16'h0003);
      cval = 16'($random(seed));
      wr(OFS_COUNT, cval);
      rd_chk(OFS_COUNT, cval, 16'hffff);
      // Every writable field but the flag set, edge left off so no capture can fire
      wr(OFS_CTL, 16'h39f6);
      idle(6);
      rd_chk(OFS_CTL, 16'h39fe, 16'hffff);
      for (int s = 0; s < 4; s++) begin
         input_a_line_i <= 1'($random(seed));
         input_b_line_i <= 1'($random(seed));
         wr(OFS_CTL, 16'(s) << 12);
         idle(6);
         lvl = (s == 0) ? input_a_line_i : (s == 1) ? input_b_line_i : (s == 3);
         rd_chk(OFS_CTL, (16'(s) << 12) | (16'(lvl) << 3), 16'hffff);
      end
      wr(OFS_CTL, 16'h0004);
      idle(2);
      probe_chk(16'h0002, 16'h0002);
      wr(OFS_CTL, 16'h0000);
      idle(2);
      probe_chk(16'h0000, 16'h0002);
      // Compare at 20, wrap at 40: first run crosses only the compare point
      wr(OFS_CCR, 16'h0014);
      wr(OFS_PERIOD, 16'h0028);
      for (int m = 0; m < 8; m++) begin
         wr(OFS_CTL, 16'h0000);
         wr(OFS_COUNT, 16'h000f);
         wr(OFS_CTL, 16'(m) << 5);
         wr(OFS_RUN, 16'h0001);
         idle(10);
         wr(OFS_RUN, 16'h0000);
         idle(3);
         probe_chk({14'h0000, 1'(8'h5e >> m), 1'b0}, 16'h0002);
         wr(OFS_COUNT, 16'h0026);
         wr(OFS_RUN, 16'h0001);
         idle(6);
         wr(OFS_RUN, 16'h0000);
         idle(3);
         probe_chk({14'h0000, 1'(8'hd2 >> m), 1'b0}, 16'h0002);
      end
      rd_chk(OFS_STS, 16'h0001, 16'h0001);
      wr(OFS_MSK, 16'h0001);
      wr(OFS_CTL, 16'h0000);
      probe_chk(16'h0000, 16'h0001);
      wr(OFS_CTL, 16'h0010);
      probe_chk(16'h0001, 16'h0001);
      wr(OFS_STS, 16'h0007);
      probe_chk(16'h0000, 16'h0001);
      wr(OFS_MSK, 16'h0000);
      // Capture on line A for each edge setting, sync toggled along the way
      input_a_line_i <= 1'b0;
      wr(OFS_RUN, 16'h0001);
      for (int e = 0; e < 4; e++) begin
         cval = (16'(e) << 14) | (16'(e[0]) << 11) | 16'h0100;
         wr(OFS_CTL, cval);
         idle(6);
         wr(OFS_CTL, cval);
         input_a_line_i <= 1'b1;
         idle(8);
         rd_chk(OFS_CTL, {15'h0000, e[0]}, 16'h0001);
         wr(OFS_CTL, cval);
         input_a_line_i <= 1'b0;
         idle(8);
         rd_chk(OFS_CTL, {15'h0000, e[1]}, 16'h0001);
      end
      // Second capture before the flag is handled
      wr(OFS_CTL, cval);
      input_a_line_i <= 1'b1;
      idle(8);
      input_a_line_i <= 1'b0;
      idle(8);
      rd_chk(OFS_CTL, 16'h0003, 16'h0003);
      idle(20);
      rd_chk(OFS_CTL, 16'h0002, 16'h0002);
      // Overflow status reaches the line only through its own mask bit
      rd_chk(OFS_STS, 16'h0002, 16'h0002);
      wr(OFS_MSK, 16'h0002);
      probe_chk(16'h0001, 16'h0001);
      wr(OFS_STS, 16'h0002);
      probe_chk(16'h0000, 16'h0001);
      wr(OFS_MSK, 16'h0000);
      wr(OFS_CTL, cval);
      rd_chk(OFS_CTL, 16'h0000, 16'h0003);
      idle(4);
      // Mid-run reset with the counter running and fields written
      rst_i <= 1'b1;
      idle(3);
      rst_i <= 1'b0;
      rd_chk(OFS_CTL, 16'h0000, 16'hffff);
      rd_chk(OFS_COUNT, RST_COUNT, 16'hffff);
      rd_chk(OFS_STS, 16'h0000, 16'hffff);
      probe_chk(16'h0000, 16'h0003);
      idle(4);
      tally_and_finish();
   end

endmodule : testbench
